// ==== adcgf_regs.sv ====
// Global function register bank behind the 3-wire serial port, with its data path
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Global bit picks full power-down (0) or standby (1) for the pin.
// - Stabilizer bit: 0 off, 1 on; on after reset.
// - Sample clock divided by divide field plus one; zero means undivided.
// - Nonzero test select replaces conversion data with the chosen pattern.
// - User mode: single, alternate, single once, alternate once; user pattern only.
module adcgf_regs #(
  parameter int NUM_CH = 8,
  parameter int DW = 14
) (
  input wire logic ref_clk_i, // 25 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic sclk_i, // Serial clock pin
  input wire logic csb_n_i, // Serial chip select pin
  input wire logic sdio_i, // Serial data pin, in
  output logic sdio_o, // Serial data pin, out
  output logic sdio_oe_o, // Serial data pin drive enable
  input wire logic pdwn_i, // External power-down pin
  input wire logic [NUM_CH-1:0] chan_sel_i, // Channel select from index logic
  input wire logic [DW-1:0] user_patt1_i, // User pattern 1
  input wire logic [DW-1:0] user_patt2_i, // User pattern 2
  input wire logic [NUM_CH*DW-1:0] conv_i, // Conversion results, signed
  output logic [NUM_CH*DW-1:0] data_o, // Output data per channel
  output logic sample_en_o, // Divided sample strobe
  output logic [1:0] pwr_mode_o, // Effective power mode
  output logic dcs_en_o, // Duty cycle stabilizer on
  output logic chop_en_o, // Chop mode on
  output logic xfer_o // Override transfer pulse
);
  logic [2:0] sclk_sync_reg, csb_sync_reg, sdio_sync_reg, pdwn_sync_reg, rd_ch;
  logic [4:0] cnt_reg;
  logic [14:0] in_sh_reg;
  logic [12:0] addr_reg;
  logic [7:0] pwr_reg, clk_reg, div_reg, chop_reg, xfer_reg, div_cnt_reg, wr_data, rd_bits;
  logic [7:0] test_reg [NUM_CH], offs_reg [NUM_CH];
  logic [1:0] uph_reg [NUM_CH];
  logic [22:0] pnl_reg;
  logic [8:0] pns_reg;
  logic rw_reg, sclk_rise, sclk_fall, cs_act, wr_fire;

  // Only the second stage feeds logic; edges come from stages two and three
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_sync_reg <= 3'h0;
      csb_sync_reg <= 3'h7;
      sdio_sync_reg <= 3'h0;
      pdwn_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      csb_sync_reg <= {csb_sync_reg[1:0], csb_n_i};
      sdio_sync_reg <= {sdio_sync_reg[1:0], sdio_i};
      pdwn_sync_reg <= {pdwn_sync_reg[1:0], pdwn_i};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cs_act = ~csb_sync_reg[1];
  assign wr_data = {in_sh_reg[6:0], sdio_sync_reg[1]};
  assign wr_fire = cs_act & sclk_rise & (cnt_reg == adcgf_pkg::BYTE_LAST) & ~rw_reg;
  // Lowest selected channel answers a read
  always_comb begin
    rd_ch = 3'h0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (chan_sel_i[c]) rd_ch = 3'(c);
    end
  end
  function automatic logic [7:0] rd_byte(input logic [12:0] a, input logic [2:0] ch);
    unique case (a)
      adcgf_pkg::OFS_PWR: rd_byte = pwr_reg;
      adcgf_pkg::OFS_CLK: rd_byte = clk_reg;
      adcgf_pkg::OFS_DIV: rd_byte = div_reg;
      adcgf_pkg::OFS_CHOP: rd_byte = chop_reg;
      adcgf_pkg::OFS_TEST: rd_byte = test_reg[ch];
      adcgf_pkg::OFS_OFFS: rd_byte = offs_reg[ch];
      adcgf_pkg::OFS_XFER: rd_byte = xfer_reg;
      default: rd_byte = 8'h00;
    endcase
  endfunction
  assign rd_bits = rd_byte(addr_reg, rd_ch); // Byte that a read shifts out

  // Serial frame: instruction then bytes, address counts down per byte
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 5'h00;
      in_sh_reg <= 15'h0000;
      rw_reg <= 1'b0;
      addr_reg <= 13'h0000;
    end else if (!cs_act) begin
      cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      in_sh_reg <= {in_sh_reg[13:0], sdio_sync_reg[1]};
      if (cnt_reg == adcgf_pkg::INSTR_LAST) begin
        rw_reg <= in_sh_reg[14];
        addr_reg <= {in_sh_reg[11:0], sdio_sync_reg[1]};
      end
      if (cnt_reg == adcgf_pkg::BYTE_LAST) begin
        cnt_reg <= adcgf_pkg::DATA_FIRST; // Streaming: next byte
        addr_reg <= addr_reg - 13'h0001;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // Read data leaves on falling edges, MSB first
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else if (!cs_act || !rw_reg || !cnt_reg[4]) begin
      sdio_oe_o <= 1'b0;
    end else if (sclk_fall) begin
      sdio_o <= rd_bits[~cnt_reg[2:0]];
      sdio_oe_o <= 1'b1;
    end
  end

  // Global registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_reg <= adcgf_pkg::RST_PWR;
      clk_reg <= adcgf_pkg::RST_CLK;
      div_reg <= adcgf_pkg::RST_DIV;
      chop_reg <= adcgf_pkg::RST_CHOP;
      xfer_reg <= adcgf_pkg::RST_XFER;
    end else begin
      xfer_reg <= 8'h00; // Self-clearing trigger
      if (wr_fire) begin
        unique case (addr_reg)
          adcgf_pkg::OFS_PWR: pwr_reg <= wr_data & 8'h23;
          adcgf_pkg::OFS_CLK: clk_reg <= wr_data & 8'h01;
          adcgf_pkg::OFS_DIV: div_reg <= wr_data & 8'h07;
          adcgf_pkg::OFS_CHOP: chop_reg <= wr_data & 8'h04;
          adcgf_pkg::OFS_XFER: xfer_reg <= wr_data & 8'h01;
          default: ;
        endcase
      end
    end
  end

  // Local registers: a write lands in every selected channel
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        test_reg[c] <= adcgf_pkg::RST_TEST;
        offs_reg[c] <= adcgf_pkg::RST_OFFS;
      end
    end else if (wr_fire) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (chan_sel_i[c] && addr_reg == adcgf_pkg::OFS_TEST) test_reg[c] <= wr_data;
        if (chan_sel_i[c] && addr_reg == adcgf_pkg::OFS_OFFS) offs_reg[c] <= wr_data;
      end
    end
  end

  // Control outputs; the pin overrides the field while asserted
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_mode_o <= adcgf_pkg::PM_RUN;
      dcs_en_o <= 1'b1;
      chop_en_o <= 1'b0;
      xfer_o <= 1'b0;
    end else begin
      if (pdwn_sync_reg[1]) begin
        pwr_mode_o <= pwr_reg[adcgf_pkg::PIN_FN_BIT] ? adcgf_pkg::PM_STBY
                                                     : adcgf_pkg::PM_PDWN;
      end else begin
        pwr_mode_o <= pwr_reg[1:0];
      end
      dcs_en_o <= clk_reg[0];
      chop_en_o <= chop_reg[adcgf_pkg::CHOP_BIT];
      xfer_o <= xfer_reg[0];
    end
  end
  property p_pin_fn;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    pdwn_sync_reg[1] |=> pwr_mode_o == ($past(pwr_reg[5]) ? 2'h2 : 2'h1);
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("pin power-down mode wrong");
  property p_mode;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !pdwn_sync_reg[1] |=> pwr_mode_o == $past(pwr_reg[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("power mode not followed");
  property p_dcs;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ##1 dcs_en_o == $past(clk_reg[0]);
  endproperty
  a_dcs: assert property (p_dcs) else $error("stabilizer enable mismatch");

  // Sample divider: one strobe every div+1 clocks
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_reg <= 8'h00;
      sample_en_o <= 1'b0;
    end else if (div_cnt_reg >= div_reg) begin
      div_cnt_reg <= 8'h00;
      sample_en_o <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      sample_en_o <= 1'b0;
    end
  end
  // Ratio must hold over the whole spacing, else a rewrite would look like a fault
  property p_div;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (sample_en_o && div_reg == 8'h01) ##1 (div_reg == 8'h01) |-> !sample_en_o ##1 sample_en_o;
  endproperty
  a_div: assert property (p_div) else $error("divide by two spacing wrong");

  // Pseudorandom generators, restarted by the reset bits of channel 0
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pnl_reg <= adcgf_pkg::PNL_SEED;
      pns_reg <= adcgf_pkg::PNS_SEED;
    end else begin
      if (test_reg[0][adcgf_pkg::PN_LONG_RST_BIT]) pnl_reg <= adcgf_pkg::PNL_SEED;
      else if (sample_en_o) pnl_reg <= {pnl_reg[21:0], pnl_reg[22] ^ pnl_reg[17]};
      if (test_reg[0][adcgf_pkg::PN_SHORT_RST_BIT]) pns_reg <= adcgf_pkg::PNS_SEED;
      else if (sample_en_o) pns_reg <= {pns_reg[7:0], pns_reg[8] ^ pns_reg[4]};
    end
  end
  function automatic logic [DW-1:0] trim(input logic [DW-1:0] d, input logic [7:0] t);
    logic signed [DW:0] s;
    s = $signed({d[DW-1], d}) + $signed({{(DW-7){t[7]}}, t});
    if (s[DW] != s[DW-1]) trim = s[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    else trim = s[DW-1:0];
  endfunction

  // Data path per channel, updated on each divided sample except one that coincides with a test register write
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o <= '0;
      for (int c = 0; c < NUM_CH; c++) uph_reg[c] <= 2'h0;
    end else if (wr_fire && addr_reg == adcgf_pkg::OFS_TEST) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (chan_sel_i[c]) uph_reg[c] <= 2'h0; // New pattern restarts once modes
      end
    end else if (sample_en_o) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (pwr_mode_o != adcgf_pkg::PM_RUN) begin
          data_o[c*DW +: DW] <= '0; // Idle outputs when not running
        end else begin
          unique case (test_reg[c][3:0])
            adcgf_pkg::TP_OFF: data_o[c*DW +: DW] <= trim(conv_i[c*DW +: DW], offs_reg[c]);
            adcgf_pkg::TP_MID: data_o[c*DW +: DW] <= '0;
            adcgf_pkg::TP_PFS: data_o[c*DW +: DW] <= {1'b0, {(DW-1){1'b1}}};
            adcgf_pkg::TP_NFS: data_o[c*DW +: DW] <= {1'b1, {(DW-1){1'b0}}};
            adcgf_pkg::TP_CHK: data_o[c*DW +: DW] <= ~data_o[c*DW +: DW] == '0 ? '0 : '1;
            adcgf_pkg::TP_PNL: data_o[c*DW +: DW] <= pnl_reg[DW-1:0];
            adcgf_pkg::TP_PNS: data_o[c*DW +: DW] <= {pns_reg, pns_reg[DW-10:0]};
            adcgf_pkg::TP_WTG: data_o[c*DW +: DW] <= ~data_o[c*DW +: DW];
            adcgf_pkg::TP_USR: begin
              unique case (test_reg[c][7:6])
                adcgf_pkg::UM_SINGLE: data_o[c*DW +: DW] <= user_patt1_i;
                adcgf_pkg::UM_ALT: data_o[c*DW +: DW] <= uph_reg[c][0] ? user_patt2_i
                                                                       : user_patt1_i;
                adcgf_pkg::UM_SONCE: data_o[c*DW +: DW] <= (uph_reg[c] == 2'h0)
                                                           ? user_patt1_i : '0;
                adcgf_pkg::UM_AONCE: data_o[c*DW +: DW] <= (uph_reg[c] == 2'h0) ? user_patt1_i
                                                           : (uph_reg[c] == 2'h1)
                                                           ? user_patt2_i : '0;
              endcase
              if (uph_reg[c] != 2'h3) uph_reg[c] <= uph_reg[c] + 2'h1;
              else if (!test_reg[c][7]) uph_reg[c] <= 2'h2; // Keeps alternating
            end
            adcgf_pkg::TP_BTG: data_o[c*DW +: DW] <= {(DW/2){data_o[c*DW], ~data_o[c*DW]}};
            default: data_o[c*DW +: DW] <= {(DW/2){2'h2}};
          endcase
        end
      end
    end
  end
  // Checks on the data path
  property p_pfs;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (sample_en_o && pwr_mode_o == 2'h0 && test_reg[0][3:0] == 4'h2 && !wr_fire)
      |=> data_o[DW-1:0] == {1'b0, {(DW-1){1'b1}}};
  endproperty
  a_pfs: assert property (p_pfs) else $error("full scale pattern missing");
  property p_usr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (sample_en_o && pwr_mode_o == 2'h0 && test_reg[0] == 8'h08 && !wr_fire)
      |=> data_o[DW-1:0] == $past(user_patt1_i);
  endproperty
  a_usr: assert property (p_usr) else $error("single user pattern wrong");
  property p_trim;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (sample_en_o && pwr_mode_o == 2'h0 && test_reg[0][3:0] == 4'h0 && offs_reg[0] == 8'h00
      && !wr_fire) |=> data_o[DW-1:0] == $past(conv_i[DW-1:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("zero trim changed data");
endmodule
`default_nettype wire

// ==== adcgf_pkg.sv ====
// Shared offsets, reset values and encodings for the global function registers
package adcgf_pkg;
  localparam logic [12:0] OFS_PWR = 13'h0008;
  localparam logic [12:0] OFS_CLK = 13'h0009;
  localparam logic [12:0] OFS_DIV = 13'h000B;
  localparam logic [12:0] OFS_CHOP = 13'h000C;
  localparam logic [12:0] OFS_TEST = 13'h000D;
  localparam logic [12:0] OFS_OFFS = 13'h0010;
  localparam logic [12:0] OFS_XFER = 13'h00FF;
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_CLK = 8'h01;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_CHOP = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OFFS = 8'h00;
  localparam logic [7:0] RST_XFER = 8'h00;
  // Field positions
  localparam int PIN_FN_BIT = 5;
  localparam int CHOP_BIT = 2;
  localparam int PN_LONG_RST_BIT = 5;
  localparam int PN_SHORT_RST_BIT = 4;
  // Serial frame: 16 instruction bits, then data bytes
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST = 5'h17;
  localparam logic [4:0] DATA_FIRST = 5'h10;
  // Power modes
  localparam logic [1:0] PM_RUN = 2'h0;
  localparam logic [1:0] PM_PDWN = 2'h1;
  localparam logic [1:0] PM_STBY = 2'h2;
  localparam logic [1:0] PM_DRST = 2'h3;
  // Test pattern codes
  localparam logic [3:0] TP_OFF = 4'h0;
  localparam logic [3:0] TP_MID = 4'h1;
  localparam logic [3:0] TP_PFS = 4'h2;
  localparam logic [3:0] TP_NFS = 4'h3;
  localparam logic [3:0] TP_CHK = 4'h4;
  localparam logic [3:0] TP_PNL = 4'h5;
  localparam logic [3:0] TP_PNS = 4'h6;
  localparam logic [3:0] TP_WTG = 4'h7;
  localparam logic [3:0] TP_USR = 4'h8;
  localparam logic [3:0] TP_BTG = 4'h9;
  // User test modes
  localparam logic [1:0] UM_SINGLE = 2'h0;
  localparam logic [1:0] UM_ALT = 2'h1;
  localparam logic [1:0] UM_SONCE = 2'h2;
  localparam logic [1:0] UM_AONCE = 2'h3;
  // Seeds of the pseudorandom generators
  localparam logic [22:0] PNL_SEED = 23'h7FFFFF;
  localparam logic [8:0] PNS_SEED = 9'h1FF;
endpackage

// ==== adcgf_host.sv ====
// Serial port host model that drives 3-wire frames into the register bank
`timescale 1ns/1ps
`default_nettype none
module adcgf_host (
  input wire logic ref_clk_i, // System clock
  input wire logic sdio_i, // Resolved serial data line
  output logic sclk_o, // Serial clock, still outside frames
  output logic csb_n_o, // Chip select, active low
  output logic sdio_o, // Host data bit
  output logic sdio_oe_o // High while host drives data line
);
  // Phase length well above the 3-clock minimum, leaves room for sync delay
  localparam int HALF = 6;
  // Idle bus at time zero
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end
  // One bit: clock low with data set, sample just before the rise
  task automatic shift(input logic b, input logic drv, output logic got);
    @(posedge ref_clk_i);
    sclk_o <= 1'b0;
    sdio_o <= b;
    sdio_oe_o <= drv;
    repeat (HALF) @(posedge ref_clk_i);
    got = sdio_i;
    sclk_o <= 1'b1;
    repeat (HALF - 1) @(posedge ref_clk_i);
  endtask
  // Whole frame: instruction word then one data byte, MSB first
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] ins;
    logic g;
    ins = {rd, 2'b00, addr};
    @(posedge ref_clk_i);
    csb_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) shift(ins[i], 1'b1, g);
    for (int i = 7; i >= 0; i--) begin
      shift(wdat[i], !rd, g);
      rdat[i] = g;
    end
    repeat (HALF) @(posedge ref_clk_i);
    sclk_o <= 1'b0;
    sdio_oe_o <= 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
    csb_n_o <= 1'b1;
    repeat (2 * HALF) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== adcgf_regs_tb.sv ====
// Self-checking testbench for the global function register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module adcgf_regs_tb;
  logic clk, nrst, sclk, csb_n, h_sdio, h_oe, dut_sdio, dut_oe, sdio_q, pdwn;
  logic sample_en, dcs_en, chop_en, xfer;
  logic [1:0] pwr_mode;
  logic [7:0] chan_sel, r;
  logic [13:0] p1, p2, a, b;
  logic [111:0] conv, data;
  int fails = 0;
  int comparisons = 0;
  int xfer_cnt = 0;
  wire logic sdio_w;
  // Undriven line shows the inverse of its last level, never a stale value
  assign sdio_w = dut_oe ? dut_sdio : (h_oe ? h_sdio : ~sdio_q);
  always @(posedge clk) sdio_q <= sdio_w;
  always @(posedge clk) if (xfer === 1'b1) xfer_cnt++;
  adcgf_regs dut (.ref_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .csb_n_i(csb_n),
    .sdio_i(sdio_w), .sdio_o(dut_sdio), .sdio_oe_o(dut_oe), .pdwn_i(pdwn),
    .chan_sel_i(chan_sel), .user_patt1_i(p1), .user_patt2_i(p2), .conv_i(conv),
    .data_o(data), .sample_en_o(sample_en), .pwr_mode_o(pwr_mode), .dcs_en_o(dcs_en),
    .chop_en_o(chop_en), .xfer_o(xfer));
  adcgf_host host (.ref_clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk), .csb_n_o(csb_n),
    .sdio_o(h_sdio), .sdio_oe_o(h_oe));
  // Register access through the serial host
  task automatic wr(input logic [12:0] ad, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b0, ad, d, x);
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [12:0] ad);
    host.xfer(1'b1, ad, 8'h00, r);
  endtask
  // Two successive channel 0 samples
  task automatic sample2;
    @(posedge clk) a = data[13:0];
    @(posedge clk) b = data[13:0];
  endtask
  // Gap between two sample strobes
  task automatic period_chk(input int exp);
    int n;
    n = 0;
    while (sample_en !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sample_en !== 1'b1 && n < 50);
    `CHK(n, exp)
  endtask
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Bounded well above the roughly 14k cycles that the sequence needs
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    pdwn = 1'b0;
    chan_sel = 8'hFF;
    p1 = 14'h1234;
    p2 = 14'h0ABC;
    conv = {8{14'h0064}};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({dcs_en, chop_en, pwr_mode}, 4'h8)
    rd(adcgf_pkg::OFS_PWR); `CHK(r, adcgf_pkg::RST_PWR)
    rd(adcgf_pkg::OFS_CLK); `CHK(r, adcgf_pkg::RST_CLK)
    rd(adcgf_pkg::OFS_DIV); `CHK(r, adcgf_pkg::RST_DIV)
    rd(adcgf_pkg::OFS_CHOP); `CHK(r, adcgf_pkg::RST_CHOP)
    rd(adcgf_pkg::OFS_TEST); `CHK(r, adcgf_pkg::RST_TEST)
    rd(adcgf_pkg::OFS_OFFS); `CHK(r, adcgf_pkg::RST_OFFS)
    rd(adcgf_pkg::OFS_XFER); `CHK(r, adcgf_pkg::RST_XFER)
    rd(13'h000A); `CHK(r, 8'h00)
    // Stabilizer off, chop on
    wr(adcgf_pkg::OFS_CLK, 8'h00); `CHK(dcs_en, 1'b0)
    rd(adcgf_pkg::OFS_CLK); `CHK(r, 8'h00)
    wr(adcgf_pkg::OFS_CHOP, 8'h04); `CHK(chop_en, 1'b1)
    // Trim on all channels, then channel 7 alone at the negative end
    wr(adcgf_pkg::OFS_OFFS, 8'h05); sample2();
    `CHK({data[111:98], a}, {14'h0069, 14'h0069})
    chan_sel <= 8'h80;
    wr(adcgf_pkg::OFS_OFFS, 8'h80); sample2();
    `CHK({data[111:98], a}, {14'h3FE4, 14'h0069})
    rd(adcgf_pkg::OFS_OFFS); `CHK(r, 8'h80)
    conv <= {8{14'h1FFF}};
    sample2(); `CHK({data[111:98], b}, {14'h1F7F, 14'h1FFF})
    chan_sel <= 8'hFF;
    // Fixed patterns, then moving ones
    wr(adcgf_pkg::OFS_TEST, 8'h01); sample2(); `CHK(a, 14'h0000)
    wr(adcgf_pkg::OFS_TEST, 8'h02); sample2(); `CHK(a, 14'h1FFF)
    wr(adcgf_pkg::OFS_TEST, 8'h03); sample2(); `CHK(a, 14'h2000)
    wr(adcgf_pkg::OFS_TEST, 8'h04); sample2(); `CHK(a ^ b, 14'h3FFF)
    for (int c = 5; c < 8; c++) begin
      wr(adcgf_pkg::OFS_TEST, 8'(c)); sample2(); `CHK(a !== b, 1'b1)
    end
    // Generators held at their seeds, bit toggle, then an unlisted code
    wr(adcgf_pkg::OFS_TEST, 8'h25); sample2(); `CHK({a, b}, {14'h3FFF, 14'h3FFF})
    wr(adcgf_pkg::OFS_TEST, 8'h16); sample2(); `CHK({a, b}, {14'h3FFF, 14'h3FFF})
    wr(adcgf_pkg::OFS_TEST, 8'h09); sample2();
    `CHK({a ^ b, (a == 14'h1555 || a == 14'h2AAA)}, {14'h3FFF, 1'b1})
    wr(adcgf_pkg::OFS_TEST, 8'h0A); sample2(); `CHK({a, b}, {14'h2AAA, 14'h2AAA})
    wr(adcgf_pkg::OFS_TEST, 8'h42); sample2(); `CHK(a, 14'h1FFF)
    for (int m = 0; m < 4; m++) begin
      wr(adcgf_pkg::OFS_TEST, {2'(m), 2'b00, adcgf_pkg::TP_USR}); repeat (40) @(posedge clk);
      sample2();
      if (m == 0) `CHK({a, b}, {p1, p1})
      else if (m == 1) `CHK(a ^ b, p1 ^ p2)
      else `CHK(a | b, 14'h0000)
    end
    wr(adcgf_pkg::OFS_TEST, 8'h00);
    // Power modes: field codes, open bits masked, output gated
    for (int m = 1; m < 4; m++) begin
      wr(adcgf_pkg::OFS_PWR, 8'(m)); sample2();
      `CHK({pwr_mode, a}, {2'(m), 14'h0000})
    end
    wr(adcgf_pkg::OFS_PWR, 8'hFF); rd(adcgf_pkg::OFS_PWR); `CHK(r, 8'h23)
    wr(adcgf_pkg::OFS_PWR, 8'h00); `CHK(pwr_mode, adcgf_pkg::PM_RUN)
    // Pin effect follows the function bit
    pdwn <= 1'b1;
    repeat (6) @(posedge clk); `CHK(pwr_mode, adcgf_pkg::PM_PDWN)
    wr(adcgf_pkg::OFS_PWR, 8'h20); `CHK(pwr_mode, adcgf_pkg::PM_STBY)
    pdwn <= 1'b0;
    repeat (6) @(posedge clk); `CHK(pwr_mode, adcgf_pkg::PM_RUN)
    // Transfer pulses once and clears itself
    xfer_cnt = 0;
    wr(adcgf_pkg::OFS_XFER, 8'h01); rd(adcgf_pkg::OFS_XFER);
    `CHK({xfer_cnt, r}, {32'd1, 8'h00})
    // Divider: ratio is field plus one, largest field value too
    period_chk(1);
    wr(adcgf_pkg::OFS_DIV, 8'h01); period_chk(2);
    wr(adcgf_pkg::OFS_DIV, 8'h02); period_chk(3);
    wr(adcgf_pkg::OFS_DIV, 8'h07); period_chk(8);
    give_verdict();
  end
endmodule
`default_nettype wire
